// File: verilog/exec_params.svh
`ifndef EXEC_PARAMS_SVH
`define EXEC_PARAMS_SVH

// register port map
`define RB_GPR_LAST 8'h1f
`define RB_SSP 8'h20
`define RB_STATUS 8'h21
`define RB_CTRL 8'h22
`define CTRL_RESET 32'h0000_0001
`define STAT_PRIV_BIT 8
`define STAT_BUSY_BIT 9

// register file and stack
`define SP_IDX 5'h0f
`define SSP_RESET 32'h0000_0000
`define SR_RESET 16'h0000
`define STACK_STEP 32'h0000_0004

// trap vectors
`define VEC_COND_TRAP 8'h07
`define VEC_UNCONDITIONAL_EXCEPTION_BASE 8'h20

// test-and-set marker bit
`define TAS_MARK 8'h80

// control register codes, bits 6-5 give the width
`define CR_CCR 8'h01
`define CR_SR 8'h20
`define CR_BMR 8'h02
`define CR_GLOBAL_BANK_NUMBER_REG 8'h03
`define CR_EBR 8'h60
`define CR_RBR 8'h61
`define CR_USP 8'h62
`define CR_IBR 8'h63

`endif

// File: verilog/exec_pkg.sv
package exec_pkg;

   typedef enum logic [3:0] {
      OP_SUB_G, OP_SUB_R, OP_QUICK_REGISTER_SUBTRACT, OP_SIGN_EXTENDED_SUBTRACT, OP_SUBTRACT_WITH_EXTEND, OP_SWAP, OP_TAS, OP_TRAP_CC,
      OP_UNCONDITIONAL_EXCEPTION, OP_TST, OP_FRAME_RELEASE, OP_XCH, OP_XOR, OP_CONTROL_REG_EXCLUSIVE_OR
   } op_t;

   // 00 byte, 01 word, 1x long
   typedef logic [1:0] size_t;

   typedef struct packed {
      logic x;
      logic n;
      logic z;
      logic v;
      logic c;
   } flags_t;

   typedef struct packed {
      op_t op;
      size_t size;
      logic [31:0] src;
      logic [31:0] dst;
      logic [31:0] ea;
      logic [31:0] pc;
      logic [4:0] rs;
      logic [4:0] rd;
      logic [3:0] imm;
      logic [7:0] cr_code;
      logic cond_true;
      logic supervisor;
   } req_t;

   typedef struct packed {
      logic done;
      logic [31:0] result;
      logic dst_we;
      flags_t flags;
      logic vec_valid;
      logic [7:0] vector;
      logic flush;
      logic irq_hold;
      logic priv_fault;
   } ans_t;

   typedef struct packed {
      logic req;
      logic we;
      logic lock;
      logic [31:0] addr;
      logic [31:0] wdata;
   } mem_t;

   typedef struct packed {
      logic [31:0] res;
      flags_t f;
   } alu_t;

endpackage

// File: verilog/exec_unit.sv
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "exec_params.svh"

// Notes on behaviour
// - general subtract: destination minus source, sized
// - register subtract, global-bank registers allowed
// - quick subtract: zero-extended 4-bit immediate, all flags
// - sign-extended subtract, long result, flags kept
// - subtract with extend: source and extend flag
// - extend subtract zero flag only stays set
// - swap halves; n z set, v c cleared
// - test-and-set byte, then set bit 7
// - test-and-set as a locked read then a locked write
// - conditional trap pushes pc, sr; vector 7
// - unconditional trap vector is 32 plus immediate
// - zero test sets n z, no write
// - frame release: register to sp, then pop
// - register exchange swaps full 32-bit words
// - exclusive or; n z set, v c cleared
// - control exclusive or privileged on system registers
// - undefined control code: zero xor source, sized
// - control exclusive or flushes the prefetch queue
// - no interrupt right after control exclusive or
// - control exclusive or to ccr or sr: flags loaded from result bits 4-0
module exec_unit (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic req_valid,
   input wire exec_pkg::req_t req,
   output logic req_ready,
   output exec_pkg::ans_t ans,
   output exec_pkg::mem_t mem,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata
);
   import exec_pkg::*;

   typedef enum {S_IDLE, S_PUSH_PC, S_PUSH_SR, S_POP, S_RMW_RD, S_RMW_WR} state_t;

   state_t state_q;
   req_t req_q;
   ans_t ans_q;
   mem_t mem_q;
   flags_t flags_q;
   logic [15:0] sr_q;
   logic [31:0] ssp_q, ctrl_q, rdata_q;
   logic [31:0] gpr_q [32];
   logic [31:0] sys_q [6];
   logic [7:0] vec_q;
   logic ready_q, priv_q, go;
   logic [31:0] rs_v, rd_v, sp_v, cr_v;
   alu_t alu;
   logic w0_en, w1_en, cr_known, cr_priv;
   logic [4:0] w0_idx, w1_idx;
   logic [31:0] w0_data, w1_data;
   logic [2:0] sys_idx;

   // shifts the operand width up to bit 31 so one datapath serves all sizes
   function automatic logic [4:0] shamt(input size_t sz);
      return sz[1] ? 5'h00 : (sz[0] ? 5'h10 : 5'h18);
   endfunction

   function automatic alu_t alu_sub(input logic [31:0] a, input logic [31:0] b, input logic cin,
                                    input size_t sz);
      alu_t o;
      logic [31:0] as;
      logic [31:0] bs;
      logic [32:0] d;
      as = a << shamt(sz);
      bs = b << shamt(sz);
      d = {1'b0, as} - {1'b0, bs} - ({32'h0, cin} << shamt(sz));
      o.res = d[31:0] >> shamt(sz);
      o.f.c = d[32];
      o.f.x = d[32];
      o.f.n = d[31];
      o.f.z = (d[31:0] == 32'h0);
      o.f.v = (as[31] ^ bs[31]) & (as[31] ^ d[31]);
      return o;
   endfunction

   // logical result: n z from the sized value, v c cleared, x kept
   function automatic alu_t alu_log(input logic [31:0] r, input size_t sz, input logic x);
      alu_t o;
      logic [31:0] rsh;
      rsh = r << shamt(sz);
      o.res = r;
      o.f.x = x;
      o.f.n = rsh[31];
      o.f.z = (rsh == 32'h0);
      o.f.v = 1'b0;
      o.f.c = 1'b0;
      return o;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input size_t sz);
      return sz[1] ? nw : (sz[0] ? {old[31:16], nw[15:0]} : {old[31:8], nw[7:0]});
   endfunction

   function automatic logic [31:0] sext(input logic [31:0] v, input size_t sz);
      return sz[1] ? v : (sz[0] ? {{16{v[15]}}, v[15:0]} : {{24{v[7]}}, v[7:0]});
   endfunction

   assign req_ready = ready_q;
   assign ans = ans_q;
   assign mem = mem_q;
   assign reg_rdata = rdata_q;

   assign go = (state_q == S_IDLE) && req_valid && ready_q;
   assign rs_v = gpr_q[req.rs];
   assign rd_v = gpr_q[req.rd];
   assign sp_v = gpr_q[`SP_IDX];

   always_comb begin
      case (req.op)
         OP_SUB_G: alu = alu_sub(req.dst, req.src, 1'b0, req.size);
         OP_SUB_R: alu = alu_sub(rd_v, rs_v, 1'b0, req.size);
         OP_QUICK_REGISTER_SUBTRACT: alu = alu_sub(rd_v, {28'h0, req.imm}, 1'b0, req.size);
         OP_SIGN_EXTENDED_SUBTRACT: alu = alu_sub(req.dst, sext(req.src, req.size), 1'b0, 2'b10);
         OP_SUBTRACT_WITH_EXTEND: alu = alu_sub(req.dst, req.src, flags_q.x, req.size);
         OP_SWAP: alu = alu_log(req.size[1] ? {req.dst[15:0], req.dst[31:16]} :
                                {req.dst[31:16], req.dst[7:0], req.dst[15:8]}, req.size, flags_q.x);
         OP_TST: alu = alu_log(req.dst, req.size, flags_q.x);
         OP_XOR: alu = alu_log(req.dst ^ req.src, req.size, flags_q.x);
         OP_CONTROL_REG_EXCLUSIVE_OR: alu = alu_log(cr_v ^ req.src, req.cr_code[6:5], flags_q.x);
         default: alu = alu_log(req.dst, req.size, flags_q.x);
      endcase
   end

   always_comb begin
      cr_known = 1'b1;
      cr_priv = 1'b1;
      sys_idx = 3'h0;
      case (req.cr_code)
         `CR_CCR: cr_priv = 1'b0;
         `CR_SR: sys_idx = 3'h0;
         `CR_BMR: sys_idx = 3'h0;
         `CR_GLOBAL_BANK_NUMBER_REG: sys_idx = 3'h1;
         `CR_EBR: sys_idx = 3'h2;
         `CR_RBR: sys_idx = 3'h3;
         `CR_USP: sys_idx = 3'h4;
         `CR_IBR: sys_idx = 3'h5;
         default: begin
            cr_known = 1'b0;
            cr_priv = 1'b0;
         end
      endcase
      if (req.cr_code == `CR_CCR) begin
         cr_v = {27'h0, flags_q};
      end else if (req.cr_code == `CR_SR) begin
         cr_v = {16'h0, sr_q[15:5], flags_q};
      end else if (cr_known) begin
         cr_v = sys_q[sys_idx];
      end else begin
         cr_v = 32'h0;
      end
   end

   // register file write ports
   always_comb begin
      w0_en = 1'b0;
      w0_idx = req.rd;
      w0_data = 32'h0;
      w1_en = 1'b0;
      w1_idx = `SP_IDX;
      w1_data = 32'h0;
      if (go) begin
         case (req.op)
            OP_SUB_R, OP_QUICK_REGISTER_SUBTRACT: begin
               w0_en = 1'b1;
               w0_data = merge(rd_v, alu.res, req.size);
            end
            OP_XCH: begin
               w0_en = 1'b1;
               w0_data = rs_v;
               w1_en = 1'b1;
               w1_idx = req.rs;
               w1_data = rd_v;
            end
            OP_FRAME_RELEASE: begin
               w1_en = 1'b1;
               w1_data = rd_v;
            end
            default: w0_en = 1'b0;
         endcase
      end else if (state_q == S_POP && mem_ack) begin
         w1_en = 1'b1;
         w1_data = sp_v + `STACK_STEP;
         w0_en = 1'b1;
         w0_idx = req_q.rd;
         w0_data = mem_rdata;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < 32; i++) begin
            gpr_q[i] <= 32'h0;
         end
      end else if (ce) begin
         if (reg_wr && reg_addr <= `RB_GPR_LAST) gpr_q[reg_addr[4:0]] <= reg_wdata;
         if (w1_en) gpr_q[w1_idx] <= w1_data;
         if (w0_en) gpr_q[w0_idx] <= w0_data;
      end
   end

   // register port: control, status and read data
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q <= `CTRL_RESET;
         priv_q <= 1'b0;
         rdata_q <= 32'h0;
      end else if (ce) begin
         if (reg_wr && reg_addr == `RB_CTRL) ctrl_q <= reg_wdata;
         if (ans_q.done && ans_q.priv_fault) begin
            priv_q <= 1'b1;
         end else if (reg_wr && reg_addr == `RB_STATUS && reg_wdata[`STAT_PRIV_BIT]) begin
            priv_q <= 1'b0;
         end
         rdata_q <= 32'h0;
         if (reg_rd) begin
            if (reg_addr <= `RB_GPR_LAST) begin
               rdata_q <= gpr_q[reg_addr[4:0]];
            end else if (reg_addr == `RB_SSP) begin
               rdata_q <= ssp_q;
            end else if (reg_addr == `RB_STATUS) begin
               rdata_q <= {22'h0, state_q != S_IDLE, priv_q, 3'h0, flags_q};
            end else if (reg_addr == `RB_CTRL) begin
               rdata_q <= ctrl_q;
            end
         end
      end
   end

   // instruction engine
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= S_IDLE;
         req_q <= '0;
         ans_q <= '0;
         mem_q <= '0;
         flags_q <= '0;
         sr_q <= `SR_RESET;
         ssp_q <= `SSP_RESET;
         vec_q <= 8'h0;
         ready_q <= 1'b0;
         for (int i = 0; i < 6; i++) begin
            sys_q[i] <= 32'h0;
         end
      end else if (ce) begin
         ans_q.done <= 1'b0;
         ans_q.dst_we <= 1'b0;
         ans_q.vec_valid <= 1'b0;
         ans_q.flush <= 1'b0;
         ans_q.priv_fault <= 1'b0;
         if (reg_wr && reg_addr == `RB_SSP) ssp_q <= reg_wdata;
         case (state_q)
            S_IDLE: begin
               ready_q <= ctrl_q[0];
               if (go) begin
                  req_q <= req;
                  ready_q <= 1'b0;
                  ans_q.done <= 1'b1;
                  ans_q.irq_hold <= 1'b0;
                  ans_q.result <= alu.res;
                  case (req.op)
                     OP_SUB_G, OP_XOR, OP_SWAP: begin
                        ans_q.dst_we <= 1'b1;
                        flags_q <= alu.f;
                     end
                     OP_SUB_R, OP_QUICK_REGISTER_SUBTRACT, OP_TST: flags_q <= alu.f;
                     OP_SIGN_EXTENDED_SUBTRACT: ans_q.dst_we <= 1'b1;
                     OP_SUBTRACT_WITH_EXTEND: begin
                        ans_q.dst_we <= 1'b1;
                        flags_q <= {alu.f.x, alu.f.n, alu.f.z & flags_q.z, alu.f.v, alu.f.c};
                     end
                     OP_TAS: begin
                        ans_q.done <= 1'b0;
                        mem_q <= '{req: 1'b1, we: 1'b0, lock: 1'b1, addr: req.ea, wdata: 32'h0};
                        state_q <= S_RMW_RD;
                     end
                     OP_TRAP_CC, OP_UNCONDITIONAL_EXCEPTION: begin
                        if (req.op == OP_UNCONDITIONAL_EXCEPTION || req.cond_true) begin
                           ans_q.done <= 1'b0;
                           vec_q <= (req.op == OP_UNCONDITIONAL_EXCEPTION) ? `VEC_UNCONDITIONAL_EXCEPTION_BASE + {4'h0, req.imm} : `VEC_COND_TRAP;
                           mem_q <= '{req: 1'b1, we: 1'b1, lock: 1'b0, addr: ssp_q - `STACK_STEP, wdata: req.pc};
                           state_q <= S_PUSH_PC;
                        end
                     end
                     OP_FRAME_RELEASE: begin
                        ans_q.done <= 1'b0;
                        mem_q <= '{req: 1'b1, we: 1'b0, lock: 1'b0, addr: rd_v, wdata: 32'h0};
                        state_q <= S_POP;
                     end
                     OP_CONTROL_REG_EXCLUSIVE_OR: begin
                        if (cr_priv && !req.supervisor) begin
                           ans_q.priv_fault <= 1'b1;
                        end else begin
                           ans_q.flush <= 1'b1;
                           ans_q.irq_hold <= 1'b1;
                           if (req.cr_code == `CR_CCR || req.cr_code == `CR_SR) begin
                              flags_q <= alu.res[4:0];
                              if (req.cr_code == `CR_SR) begin
                                 sr_q <= alu.res[15:0];
                              end
                           end else if (cr_known) begin
                              sys_q[sys_idx] <= alu.res;
                           end else begin
                              flags_q <= alu.f;
                           end
                        end
                     end
                     default: ans_q.dst_we <= 1'b0;
                  endcase
               end
            end
            S_PUSH_PC: begin
               if (mem_ack) begin
                  ssp_q <= ssp_q - `STACK_STEP;
                  mem_q.addr <= ssp_q - `STACK_STEP - `STACK_STEP;
                  mem_q.wdata <= {16'h0, sr_q[15:5], flags_q};
                  state_q <= S_PUSH_SR;
               end
            end
            S_PUSH_SR: begin
               if (mem_ack) begin
                  ssp_q <= ssp_q - `STACK_STEP;
                  mem_q <= '0;
                  ans_q.done <= 1'b1;
                  ans_q.vec_valid <= 1'b1;
                  ans_q.vector <= vec_q;
                  state_q <= S_IDLE;
               end
            end
            S_POP: begin
               if (mem_ack) begin
                  mem_q <= '0;
                  ans_q.done <= 1'b1;
                  state_q <= S_IDLE;
               end
            end
            S_RMW_RD: begin
               if (mem_ack) begin
                  // byte compared with zero, bit 7 set
                  flags_q <= {flags_q.x, mem_rdata[7], mem_rdata[7:0] == 8'h0, 2'b00};
                  mem_q.we <= 1'b1;
                  mem_q.wdata <= {24'h0, mem_rdata[7:0] | `TAS_MARK};
                  ans_q.result <= {24'h0, mem_rdata[7:0] | `TAS_MARK};
                  state_q <= S_RMW_WR;
               end
            end
            S_RMW_WR: begin
               if (mem_ack) begin
                  mem_q <= '0;
                  ans_q.done <= 1'b1;
                  state_q <= S_IDLE;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

endmodule
`default_nettype wire

// File: verification/exec_unit_checker.sv
`timescale 1ns/100ps
`default_nettype none
`include "exec_params.svh"
module exec_unit_checker (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic req_valid,
   input wire exec_pkg::req_t req,
   input wire logic req_ready,
   input wire exec_pkg::ans_t ans,
   input wire exec_pkg::mem_t mem,
   input wire logic mem_ack
);
   import exec_pkg::*;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   logic take;
   op_t op_q;
   logic [3:0] imm_q;
   assign take = req_valid && req_ready && ce;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         op_q <= OP_SUB_G;
         imm_q <= 4'h0;
      end else if (take) begin
         op_q <= req.op;
         imm_q <= req.imm;
      end
   end
   sequence s_lock_rd;
      mem.req && mem.lock && !mem.we && mem_ack;
   endsequence
   sequence s_lock_wr;
      mem.req && mem.lock && mem.we && mem.wdata[7];
   endsequence
   a_tas_locked: assert property (s_lock_rd |=> s_lock_wr)
      else $error("locked write does not follow locked read");
   a_bus_hold: assert property (mem.req && !mem_ack |=> $stable(mem))
      else $error("bus request changed before ack");
   a_ready_drops: assert property (take |=> !req_ready)
      else $error("ready stayed high after take");
   a_alu_done: assert property (take && !(req.op inside {OP_TAS, OP_UNCONDITIONAL_EXCEPTION, OP_FRAME_RELEASE, OP_TRAP_CC})
      |=> ans.done)
      else $error("done not one cycle after take");
   a_trap_skip: assert property (take && req.op == OP_TRAP_CC && !req.cond_true
      |=> ans.done && !ans.vec_valid)
      else $error("false condition trap started exception");
   a_trap_vec: assert property (ans.vec_valid && op_q == OP_TRAP_CC |-> ans.vector == 8'h07)
      else $error("conditional trap vector wrong");
   a_unconditional_exception_vec: assert property (ans.vec_valid && op_q == OP_UNCONDITIONAL_EXCEPTION
      |-> ans.vector == 8'h20 + {4'h0, imm_q})
      else $error("unconditional trap vector wrong");
   a_test_nowr: assert property (ans.done && op_q == OP_TST |-> !ans.dst_we)
      else $error("zero test wrote destination");
   a_control_reg_exclusive_or_flush: assert property (ans.done && op_q == OP_CONTROL_REG_EXCLUSIVE_OR && !ans.priv_fault
      |-> ans.flush && ans.irq_hold)
      else $error("control xor without flush or hold");
   a_irq_hold: assert property (ans.irq_hold && !take |=> ans.irq_hold)
      else $error("interrupt hold dropped early");
   a_priv_fault: assert property (take && req.op == OP_CONTROL_REG_EXCLUSIVE_OR && !req.supervisor && req.cr_code inside
      {`CR_BMR, `CR_GLOBAL_BANK_NUMBER_REG, `CR_SR, `CR_EBR, `CR_RBR, `CR_USP, `CR_IBR} |=> ans.done && ans.priv_fault)
      else $error("privileged control xor not refused");
endmodule
bind exec_unit exec_unit_checker chk_i (.core_clk(core_clk), .rst_b(rst_b), .ce(ce), .req_valid(req_valid),
   .req(req), .req_ready(req_ready), .ans(ans), .mem(mem), .mem_ack(mem_ack));
`default_nettype wire

// File: verification/mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module mem_model (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire exec_pkg::mem_t mem,
   input wire logic [1:0] slow,
   output logic mem_ack,
   output logic [31:0] mem_rdata
);
   import exec_pkg::*;
   logic [31:0] m [logic [31:0]];
   logic [31:0] rd_q;
   logic [1:0] wt_q;
   // outside an ack the data lines carry garbage
   assign mem_rdata = mem_ack ? rd_q : ~rd_q;
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         mem_ack <= 1'b0;
         wt_q <= 2'h0;
         rd_q <= 32'h0;
      end else if (mem_ack) begin
         mem_ack <= 1'b0;
      end else if (mem.req && wt_q < slow) begin
         wt_q <= wt_q + 2'h1;
      end else if (mem.req) begin
         wt_q <= 2'h0;
         mem_ack <= 1'b1;
         if (mem.we)
            m[mem.addr] = mem.wdata;
         else
            rd_q <= m[mem.addr];
      end
   end
endmodule
`default_nettype wire

// File: verification/cpu_instr_sub_to_control_reg_exclusive_or_exec_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "exec_params.svh"
module cpu_instr_sub_to_control_reg_exclusive_or_exec_tb_top;
   import exec_pkg::*;
   logic core_clk, rst_b, ce, reg_wr, reg_rd, req_valid, req_ready, mem_ack;
   logic [7:0] reg_addr, b;
   logic [31:0] reg_wdata, reg_rdata, mem_rdata, v, m, r, d, s;
   logic [1:0] slow;
   req_t req, q;
   ans_t ans, a;
   mem_t mem;
   flags_t fl, f;
   int error_cnt, n_tests, cyc, i;
   op_t alu [6] = '{OP_SUB_G, OP_SIGN_EXTENDED_SUBTRACT, OP_SUBTRACT_WITH_EXTEND, OP_SWAP, OP_TST, OP_XOR};
   logic [7:0] xc [4] = '{`CR_CCR, `CR_SR, 8'h70, 8'h10};
   exec_unit dut (.core_clk(core_clk), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .ans(ans), .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   mem_model mdl (.core_clk(core_clk), .rst_b(rst_b), .mem(mem), .slow(slow), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata));
   always #25 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         wrap_up();
      end
   end
   function automatic logic [31:0] msk(size_t z);
      return z == 2'b00 ? 32'hff : z == 2'b01 ? 32'hffff : 32'hffff_ffff;
   endfunction
   function automatic logic top(logic [31:0] x, size_t z);
      return z == 2'b00 ? x[7] : z == 2'b01 ? x[15] : x[31];
   endfunction
   function automatic flags_t lf(logic [31:0] x, size_t z);
      return {fl.x, top(x, z), (x & msk(z)) == 32'h0, 2'b00};
   endfunction
   function automatic flags_t sf(logic [31:0] x, y, logic ci, size_t z);
      logic [31:0] t;
      flags_t g;
      t = (x - y - 32'(ci)) & msk(z);
      g.c = {1'b0, x & msk(z)} < {1'b0, y & msk(z)} + 33'(ci);
      g.x = g.c;
      g.n = top(t, z);
      g.z = t == 32'h0;
      g.v = (top(x, z) != top(y, z)) && (top(t, z) != top(x, z));
      return g;
   endfunction
   function automatic req_t mk(op_t o, size_t z, logic [31:0] x);
      req_t t;
      t = '0;
      t.op = o;
      t.size = z;
      t.src = x;
      t.dst = $urandom;
      return t;
   endfunction
   task automatic chk(input string nm, input logic [31:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] x);
      reg_addr <= ad;
      reg_wdata <= x;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [7:0] ad, output logic [31:0] x);
      reg_addr <= ad;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      x = reg_rdata;
      @(posedge core_clk);
   endtask
   task automatic ckf(input string nm);
      rd(`RB_STATUS, v);
      chk(nm, 32'(v[4:0]), 32'(fl));
   endtask
   task automatic go(input req_t t);
      int k;
      req <= t;
      req_valid <= 1'b1;
      slow <= 2'($urandom);
      do @(negedge core_clk); while (req_ready !== 1'b1);
      @(posedge core_clk);
      req_valid <= 1'b0;
      k = 0;
      do begin
         @(negedge core_clk);
         k++;
      end while (ans.done !== 1'b1 && k < 40);
      a = ans;
      chk("done", 32'(ans.done), 32'h1);
      @(posedge core_clk);
   endtask
   task automatic wrap_up();
      $display("tests %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      rst_b = 1'b0;
      ce = 1'b1;
      {reg_wr, reg_rd, req_valid, reg_addr, reg_wdata, slow, req, cyc, fl} = '0;
      void'($urandom(43));
      repeat (3) @(posedge core_clk);
      chk("rdy_rst", 32'(req_ready), 32'h0);
      rst_b <= 1'b1;
      repeat (2) @(posedge core_clk);
      rd(`RB_CTRL, v);
      chk("ctrl", v, `CTRL_RESET);
      ckf("stat");
      wr(8'h40, 32'hffff_ffff);
      rd(8'h40, v);
      chk("unmap", v, 32'h0);
      $display("regs done");
      for (i = 0; i < 30; i++) begin
         q = mk(alu[i % 6], 2'($urandom % 3), $urandom);
         if (i < 6) q.src = q.dst;
         if (q.op == OP_SWAP && q.size == 2'b00) q.size = 2'b01;
         d = q.dst;
         s = q.src;
         m = q.op == OP_SIGN_EXTENDED_SUBTRACT ? 32'hffff_ffff : msk(q.size);
         go(q);
         case (q.op)
            OP_SUB_G: fl = sf(d, s, 1'b0, q.size);
            OP_SUBTRACT_WITH_EXTEND: begin
               f = sf(d, s, fl.x, q.size);
               f.z = f.z & fl.z;
               r = d - s - 32'(fl.x);
               fl = f;
            end
            OP_SIGN_EXTENDED_SUBTRACT: r = d - (q.size[1] ? s : q.size[0] ? 32'(signed'(s[15:0])) : 32'(signed'(s[7:0])));
            OP_SWAP: r = q.size == 2'b01 ? {16'h0, d[7:0], d[15:8]} : {d[15:0], d[31:16]};
            OP_XOR: r = d ^ s;
            default: r = d;
         endcase
         if (q.op == OP_SUB_G) r = d - s;
         if (q.op inside {OP_SWAP, OP_XOR, OP_TST}) fl = lf(r, q.size);
         if (q.op != OP_TST) chk("res", a.result & m, r & m);
         chk("we", 32'(a.dst_we), 32'(q.op != OP_TST));
         ckf("alu_f");
      end
      $display("alu done");
      wr(8'h11, 32'h5);
      wr(8'h12, 32'h3);
      q = mk(OP_SUB_R, 2'b10, 32'h0);
      q.rs = 5'h11;
      q.rd = 5'h12;
      go(q);
      rd(8'h12, v);
      chk("subr", v, 32'hffff_fffe);
      q.op = OP_QUICK_REGISTER_SUBTRACT;
      q.rd = 5'h11;
      q.imm = 4'hf;
      go(q);
      rd(8'h11, v);
      chk("subrq", v, 32'hffff_fff6);
      fl = sf(32'h5, 32'hf, 1'b0, 2'b10);
      ckf("subrq_f");
      q.op = OP_XCH;
      q.rd = 5'h12;
      go(q);
      rd(8'h11, v);
      chk("xch_a", v, 32'hffff_fffe);
      rd(8'h12, v);
      chk("xch_b", v, 32'hffff_fff6);
      ce <= 1'b0;
      wr(8'h11, 32'h1);
      ce <= 1'b1;
      rd(8'h11, v);
      chk("ce_hold", v, 32'hffff_fffe);
      for (i = 0; i < 2; i++) begin
         b = i ? 8'h85 : 8'h00;
         mdl.m[32'h40] = {24'h0, b};
         q = mk(OP_TAS, 2'b00, 32'h0);
         q.ea = 32'h40;
         go(q);
         chk("tas_m", mdl.m[32'h40] & 32'hff, 32'(b | 8'h80));
         fl = lf(32'(b), 2'b00);
         ckf("tas_f");
      end
      $display("reg and tas done");
      for (i = 0; i < 4; i++) begin
         wr(`RB_SSP, 32'h100);
         q = mk(i < 2 ? OP_TRAP_CC : OP_UNCONDITIONAL_EXCEPTION, 2'b00, 32'h0);
         q.cond_true = i[0];
         q.imm = i == 3 ? 4'hf : 4'h0;
         q.pc = $urandom;
         go(q);
         rd(`RB_SSP, v);
         chk("ssp", v, i == 0 ? 32'h100 : 32'hf8);
         chk("vec_v", 32'(a.vec_valid), 32'(i > 0));
         if (i > 0) begin
            chk("vec", 32'(a.vector), i == 1 ? 32'h7 : 32'h20 + 32'(q.imm));
            chk("push_pc", mdl.m[32'hfc], q.pc);
            chk("push_sr", mdl.m[32'hf8] & 32'h1f, 32'(fl));
         end
      end
      wr(8'h05, 32'h200);
      mdl.m[32'h200] = $urandom;
      q = mk(OP_FRAME_RELEASE, 2'b10, 32'h0);
      q.rd = 5'h05;
      go(q);
      rd(8'h05, v);
      chk("frame_release_r", v, mdl.m[32'h200]);
      rd(8'(`SP_IDX), v);
      chk("frame_release_sp", v, 32'h204);
      $display("trap and unlink done");
      for (i = 0; i < 4; i++) begin
         q = mk(OP_CONTROL_REG_EXCLUSIVE_OR, 2'b00, i < 2 ? 32'($urandom % 32) : $urandom);
         q.supervisor = 1'b1;
         q.cr_code = xc[i];
         go(q);
         fl = i < 2 ? fl ^ flags_t'(q.src[4:0]) : lf(q.src, i == 2 ? 2'b11 : 2'b00);
         chk("flush", 32'(a.flush), 32'h1);
         chk("hold", 32'(a.irq_hold), 32'h1);
         ckf("control_reg_exclusive_or_f");
      end
      q.cr_code = `CR_BMR;
      q.supervisor = 1'b0;
      go(q);
      chk("priv", 32'(a.priv_fault), 32'h1);
      rd(`RB_STATUS, v);
      chk("priv_s", 32'(v[8]), 32'h1);
      wr(`RB_STATUS, 32'h100 | 32'(fl));
      rd(`RB_STATUS, v);
      chk("priv_c", 32'(v[8]), 32'h0);
      $display("control_reg_exclusive_or done");
      wrap_up();
   end
endmodule
`default_nettype wire
